/* hw/srg_pkg.sv */
package srg_pkg;
   localparam int STAGE_COUNT = 8;
   localparam int SEL_WIDTH = 3;
   localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 8'h00;
   localparam int FIFO_DEPTH = 32;
   localparam int CLK_PERIOD_NS = 100;
   // one program cycle of the controller
   localparam int EVAL_PERIOD_NS = 100000;
   localparam int EVAL_TICKS = EVAL_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 3;
   localparam int PIN_COUNT = 4;
   localparam int PIN_DATA = 0;
   localparam int PIN_TRIG = 1;
   localparam int PIN_DIR = 2;
   localparam int PIN_RESTART = 3;

   typedef struct packed {
      logic shiftDown;
      logic dataBit;
   } srg_shift_t;

   localparam int SHIFT_WIDTH = $bits(srg_shift_t);
endpackage : srg_pkg

/* hw/srg_shift_register.sv */
// Behaviour
// - trigger rising edge samples input, one shift
// - trigger falling edge does nothing
// - direction low: input into first_stage, shift up
// - direction high: input into last_stage, shift down
// - output follows configured stage
// - non-retentive restart clears all stages
// - retentive restart keeps all stages together
// - stage selection and retentivity fixed while running
`timescale 1ns/1ns

module srg_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   logic doWrite;
   logic doRead;

   assign inReady = count_reg != DEPTH_C;
   assign outValid = count_reg != '0;
   assign outData = mem_reg[rdPtr_reg];
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   always_ff @(posedge mclk)
   begin
      if (doWrite)
         mem_reg[wrPtr_reg] <= inData;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         {wrPtr_reg, rdPtr_reg, count_reg} <= '0;
      else
      begin
         if (doWrite)
            wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
         if (doRead)
            rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
         if (doWrite && !doRead)
            count_reg <= count_reg + 1'b1;
         else if (doRead && !doWrite)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule : srg_fifo

module srg_shift_register
   import srg_pkg::*;
#(
   parameter int EVAL_CYCLES = EVAL_TICKS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // pins from outside
   input wire logic dataIn,
   input wire logic trigger,
   input wire logic direction,
   input wire logic restart,
   // configuration, caught after reset release
   input wire logic [SEL_WIDTH-1:0] outSelect,
   input wire logic retainEn,
   // same-clock stall of the shift engine
   input wire logic holdShift,
   // results
   output logic q,
   output logic overrun
);
   logic [PIN_COUNT-1:0] pins;
   logic [PIN_COUNT-1:0] sync1_reg;
   logic [PIN_COUNT-1:0] sync2_reg;
   logic [PIN_COUNT-1:0] sync3_reg;
   logic [PIN_COUNT-1:0] level_reg;
   logic [15:0] divCnt_reg;
   logic tick_reg;
   logic trigPrev_reg;
   logic restartPrev_reg;
   logic restartPulse;
   logic cfgDone_reg;
   logic [SEL_WIDTH-1:0] sel_reg;
   logic retain_reg;
   logic [STAGE_COUNT-1:0] stages_reg;
   logic [STAGE_COUNT-1:0] stages_next;
   logic push;
   logic pushReady;
   logic popValid;
   logic pop;
   srg_shift_t pushReq;
   srg_shift_t popReq;
   logic [SHIFT_WIDTH-1:0] popRaw;

   function automatic logic stageBit(input logic [STAGE_COUNT-1:0] s,
                                     input logic [SEL_WIDTH-1:0] idx);
      stageBit = s[idx];
   endfunction : stageBit

   assign pins = {restart, direction, trigger, dataIn};

   // three-stage synchronisers; level moves only when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++)
      begin : g_sync
         always_ff @(posedge mclk or negedge nrst)
         begin
            if (!nrst)
               {sync1_reg[gi], sync2_reg[gi], sync3_reg[gi], level_reg[gi]} <= 4'h0;
            else
            begin
               sync1_reg[gi] <= pins[gi];
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi];
               if (sync2_reg[gi] == sync3_reg[gi])
                  level_reg[gi] <= sync3_reg[gi];
            end
         end
      end
   endgenerate

   // program cycle enable
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         {divCnt_reg, tick_reg} <= '0;
      else if (divCnt_reg == 16'(EVAL_CYCLES - 1))
      begin
         divCnt_reg <= '0;
         tick_reg <= 1'b1;
      end
      else
      begin
         divCnt_reg <= divCnt_reg + 16'h0001;
         tick_reg <= 1'b0;
      end
   end

   // configuration caught once after release, then frozen
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         {cfgDone_reg, sel_reg, retain_reg} <= '0;
      else if (!cfgDone_reg)
      begin
         cfgDone_reg <= 1'b1;
         sel_reg <= outSelect;
         retain_reg <= retainEn;
      end
   end

   // trigger level kept per program cycle
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         trigPrev_reg <= 1'b0;
      else if (tick_reg)
         trigPrev_reg <= level_reg[PIN_TRIG];
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         restartPrev_reg <= 1'b0;
      else
         restartPrev_reg <= level_reg[PIN_RESTART];
   end

   assign restartPulse = level_reg[PIN_RESTART] && !restartPrev_reg;
   // only 0 to 1 produces a request, 1 to 0 is ignored
   assign push = tick_reg && level_reg[PIN_TRIG] && !trigPrev_reg;
   assign pushReq.shiftDown = level_reg[PIN_DIR];
   assign pushReq.dataBit = level_reg[PIN_DATA];

   srg_fifo #(
      .WIDTH(SHIFT_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) i_srg_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .inValid(push),
      .inReady(pushReady),
      .inData(pushReq),
      .outValid(popValid),
      .outReady(!holdShift && !restartPulse),
      .outData(popRaw)
   );

   assign popReq = srg_shift_t'(popRaw);
   assign pop = popValid && !holdShift && !restartPulse;

   // lost edge when the queue is full
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         overrun <= 1'b0;
      else if (push && !pushReady)
         overrun <= 1'b1;
   end

   always_comb
   begin
      if (!popReq.shiftDown)
         stages_next = {stages_reg[STAGE_COUNT-2:0], popReq.dataBit};
      else
         stages_next = {popReq.dataBit, stages_reg[STAGE_COUNT-1:1]};
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         stages_reg <= STAGE_RESET;
      else if (restartPulse)
      begin
         if (!retain_reg)
            stages_reg <= STAGE_RESET;
      end
      else if (pop)
         stages_reg <= stages_next;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         q <= 1'b0;
      else
         q <= stageBit(stages_reg, sel_reg);
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   property p_shift_up;
      pop && !popReq.shiftDown |=>
         stages_reg == {$past(stages_reg[STAGE_COUNT-2:0]), $past(popReq.dataBit)};
   endproperty
   a_shift_up: assert property (p_shift_up) else $error("upward shift wrong");
   property p_shift_down;
      pop && popReq.shiftDown |=>
         stages_reg == {$past(popReq.dataBit), $past(stages_reg[STAGE_COUNT-1:1])};
   endproperty
   a_shift_down: assert property (p_shift_down) else $error("downward shift wrong");
   property p_no_pop_stable;
      !pop && !restartPulse |=> $stable(stages_reg);
   endproperty
   a_no_pop_stable: assert property (p_no_pop_stable) else $error("stages moved");
   // a falling trigger seen at a tick must leave an empty queue empty
   property p_fall_no_push;
      tick_reg && trigPrev_reg && !level_reg[PIN_TRIG] && !popValid |=> !popValid;
   endproperty
   a_fall_no_push: assert property (p_fall_no_push) else $error("push without rise");
   property p_rise_queued;
      push && pushReady |=> popValid;
   endproperty
   a_rise_queued: assert property (p_rise_queued) else $error("edge not queued");
   property p_out_sel;
      cfgDone_reg |=> q == $past(stages_reg[sel_reg]);
   endproperty
   a_out_sel: assert property (p_out_sel) else $error("output stage wrong");
   property p_clear;
      restartPulse && !retain_reg |=> stages_reg == STAGE_RESET;
   endproperty
   a_clear: assert property (p_clear) else $error("restart did not clear");
   property p_retain;
      restartPulse && retain_reg |=> $stable(stages_reg);
   endproperty
   a_retain: assert property (p_retain) else $error("retained stages lost");
   property p_cfg_frozen;
      cfgDone_reg |=> $stable(sel_reg) && $stable(retain_reg) && cfgDone_reg;
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed");
   property p_prev_trig;
      tick_reg |=> trigPrev_reg == $past(level_reg[PIN_TRIG]);
   endproperty
   a_prev_trig: assert property (p_prev_trig) else $error("trigger history wrong");
   c_up: cover property (pop && !popReq.shiftDown);
   c_down: cover property (pop && popReq.shiftDown);
   c_overrun: cover property (push && !pushReady);
   c_retain: cover property (restartPulse && retain_reg && stages_reg != STAGE_RESET);
endmodule : srg_shift_register

/* test/srg_shift_register_tb_top.sv */
`timescale 1ns/1ns

`define CHK(what, expv, gotv) \
   begin \
      checked++; \
      if ((gotv) !== (expv)) \
      begin \
         badCount++; \
         $display("ERROR %s expected %0h seen %0h", what, expv, gotv); \
      end \
   end

module srg_shift_register_tb_top;
   import srg_pkg::*;

   localparam int EVAL = 4;
   // covers synchroniser, tick spacing and the pop/q pipeline
   localparam int SETTLE = 16;

   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic dataIn = 1'b0;
   logic trigger = 1'b0;
   logic direction = 1'b0;
   logic restart = 1'b0;
   logic [SEL_WIDTH-1:0] outSelect = '0;
   logic retainEn = 1'b0;
   logic holdShift = 1'b0;
   logic q;
   logic overrun;
   logic [STAGE_COUNT-1:0] expStages = STAGE_RESET;
   int selNow = 0;
   int badCount = 0;
   int checked = 0;

   always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

   srg_shift_register #(.EVAL_CYCLES(EVAL)) i_srg_shift_register (
      .mclk(mclk),
      .nrst(nrst),
      .dataIn(dataIn),
      .trigger(trigger),
      .direction(direction),
      .restart(restart),
      .outSelect(outSelect),
      .retainEn(retainEn),
      .holdShift(holdShift),
      .q(q),
      .overrun(overrun)
   );

   task automatic endOfTest();
      $display("checks %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : endOfTest

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   task automatic powerOn(input int sel, input logic ret);
      @(posedge mclk);
      nrst <= 1'b0;
      outSelect <= SEL_WIDTH'(sel);
      retainEn <= ret;
      trigger <= 1'b0;
      restart <= 1'b0;
      holdShift <= 1'b0;
      cyc(20);
      nrst <= 1'b1;
      cyc(SETTLE);
      selNow = sel;
      expStages = STAGE_RESET;
      `CHK("q after reset", 1'b0, q)
   endtask : powerOn

   // one full trigger pulse; model and check are optional
   task automatic shiftOne(input logic dir, input logic val, input bit model, input bit chk);
      direction <= dir;
      dataIn <= val;
      cyc(SETTLE);
      trigger <= 1'b1;
      if (model)
         expStages = dir ? {val, expStages[STAGE_COUNT-1:1]} : {expStages[STAGE_COUNT-2:0], val};
      cyc(SETTLE);
      if (chk)
         `CHK("q after rising trigger", expStages[selNow], q)
      trigger <= 1'b0;
      cyc(SETTLE);
      if (chk)
         `CHK("q after falling trigger", expStages[selNow], q)
   endtask : shiftOne

   task automatic pulseRestart();
      restart <= 1'b1;
      cyc(SETTLE);
      restart <= 1'b0;
      cyc(SETTLE);
   endtask : pulseRestart

   // every stage selection, both directions mixed
   task automatic testSelect();
      logic [7:0] pat;
      for (int s = 0; s < STAGE_COUNT; s++)
      begin
         powerOn(s, 1'b0);
         pat = 8'hB5 ^ 8'(s * 8'h13);
         for (int i = 0; i < STAGE_COUNT; i++)
            shiftOne(logic'((s + i) % 3 == 0), pat[i], 1, 1);
      end
      $display("test select done");
   endtask : testSelect

   task automatic testRestart(input logic ret);
      powerOn(2, ret);
      for (int i = 0; i < 4; i++)
         shiftOne(1'b0, 1'b1, 1, 1);
      pulseRestart();
      if (!ret)
         expStages = STAGE_RESET;
      `CHK("q after restart", expStages[selNow], q)
      shiftOne(1'b0, 1'b1, 1, 1);
      $display("test restart retain=%0d done", ret);
   endtask : testRestart

   task automatic testConfigFixed();
      powerOn(1, 1'b0);
      shiftOne(1'b0, 1'b1, 1, 1);
      shiftOne(1'b0, 1'b0, 1, 1);
      outSelect <= 3'h0;
      retainEn <= 1'b1;
      cyc(SETTLE);
      `CHK("q with select moved", 1'b1, q)
      pulseRestart();
      `CHK("q after restart, retain moved", 1'b0, q)
      $display("test config fixed done");
   endtask : testConfigFixed

   task automatic testOverrun();
      powerOn(7, 1'b0);
      holdShift <= 1'b1;
      for (int i = 0; i <= FIFO_DEPTH; i++)
      begin
         shiftOne(1'b0, logic'(i % 3 == 0), i < FIFO_DEPTH, 0);
         if (i == FIFO_DEPTH - 1)
            `CHK("overrun at full", 1'b0, overrun)
      end
      `CHK("q while held", 1'b0, q)
      `CHK("overrun after drop", 1'b1, overrun)
      holdShift <= 1'b0;
      cyc(FIFO_DEPTH + SETTLE);
      `CHK("q after drain", expStages[selNow], q)
      `CHK("overrun sticky", 1'b1, overrun)
      $display("test overrun done");
   endtask : testOverrun

   initial
   begin
      cyc(100000);
      badCount++;
      $display("ERROR watchdog expected finish seen hang");
      endOfTest();
   end

   initial
   begin
      testSelect();
      testRestart(1'b0);
      testRestart(1'b1);
      testConfigFixed();
      testOverrun();
      endOfTest();
   end
endmodule : srg_shift_register_tb_top
